// File: src/ifd_defs.svh
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH

// Instruction length limit, in bytes
`define IFD_MAX_LEN 4'hf
`define IFD_GP_ERR_CODE 16'h0000

// Prefix byte values
`define IFD_PFX_ES 8'h26
`define IFD_PFX_CS 8'h2e
`define IFD_PFX_SS 8'h36
`define IFD_PFX_DS 8'h3e
`define IFD_PFX_FS 8'h64
`define IFD_PFX_GS 8'h65
`define IFD_PFX_OPSZ 8'h66
`define IFD_PFX_ADSZ 8'h67
`define IFD_PFX_LOCK 8'hf0
`define IFD_PFX_REPNE 8'hf2
`define IFD_PFX_REP 8'hf3
`define IFD_ESC_2BYTE 8'h0f

// Segment override codes
`define IFD_SEG_ES 3'h0
`define IFD_SEG_CS 3'h1
`define IFD_SEG_SS 3'h2
`define IFD_SEG_DS 3'h3
`define IFD_SEG_FS 3'h4
`define IFD_SEG_GS 3'h5

// Field positions in the addressing-form and scaled-index bytes
`define IFD_HI_MSB 7
`define IFD_HI_LSB 6
`define IFD_MID_MSB 5
`define IFD_MID_LSB 3
`define IFD_LO_MSB 2
`define IFD_LO_LSB 0

// Opcode field bits
`define IFD_W_BIT 0
`define IFD_S_BIT 1

// Clock-count adjustments
`define IFD_CLK_TWO_REG 4'h1
`define IFD_CLK_MIS_RW 4'h1
`define IFD_CLK_MIS_RMW 4'h2
`define IFD_CLK_NC_X2 4'h2
`define IFD_CLK_NC_X3 4'h4

`endif

// File: src/ifd_pkg.sv
package ifd_pkg;

  typedef enum logic [2:0] {ST_PFX, ST_OPC2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM} ifd_state_type;

  typedef enum logic [1:0] {IMM_NONE, IMM_B8, IMM_W16, IMM_OPSZ} ifd_imm_type;

  typedef enum logic [1:0] {SEG_NONE, SEG_WIDE, SEG_NARROW} ifd_seg_type;

  typedef enum logic [1:0] {OPS_8, OPS_16, OPS_32} ifd_opsize_type;

  typedef struct packed {
    logic modrm;
    ifd_imm_type imm;
    logic has_w;
    logic sext;
    logic moffs;
    ifd_seg_type seg;
  } ifd_attr_type;

endpackage

// File: src/ifd_cost_if.sv
`timescale 1ns/1ps

interface ifd_cost_if;
  logic two_reg;
  logic lock;
  logic op32;
  logic mem_rd;
  logic mem_wr;
  logic odd_addr;
  logic noncached;
  logic tripled;
  logic [3:0] extra;

  modport calc (
    input two_reg, lock, op32, mem_rd, mem_wr, odd_addr, noncached, tripled,
    output extra
  );
  modport user (
    output two_reg, lock, op32, mem_rd, mem_wr, odd_addr, noncached, tripled,
    input extra
  );
endinterface

// File: src/ifd_cost.sv
`timescale 1ns/1ps
`include "ifd_defs.svh"

module ifd_cost (
  // Access attributes in, extra clocks out
  ifd_cost_if.calc bus
);

  logic [3:0] mis;
  logic [3:0] nc;

  always_comb begin
    mis = 4'h0;
    nc = 4'h0;
    if (bus.op32 && bus.odd_addr) begin
      if (bus.mem_rd && bus.mem_wr) begin
        mis = `IFD_CLK_MIS_RMW;
      end else if (bus.mem_rd || bus.mem_wr) begin
        mis = `IFD_CLK_MIS_RW;
      end
    end
    if ((bus.noncached || bus.lock) && (bus.mem_rd || bus.mem_wr)) begin
      nc = bus.tripled ? `IFD_CLK_NC_X3 : `IFD_CLK_NC_X2;
    end
    bus.extra = mis + nc + (bus.two_reg ? `IFD_CLK_TWO_REG : 4'h0);
  end

endmodule

// File: src/ifd_instruction_decoder.sv
`timescale 1ns/1ps
`include "ifd_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module ifd_instruction_decoder #(
  parameter logic [3:0] MAX_LEN = `IFD_MAX_LEN
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Byte stream from prefetch
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Mode and access attributes from pipeline
  input wire logic dflt_op32_i,
  input wire logic dflt_addr32_i,
  input wire logic clk_tripled_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic odd_addr_i,
  input wire logic noncached_i,
  // Decoded instruction
  output logic insn_valid_o,
  output logic [3:0] insn_len_o,
  output logic two_byte_o,
  output logic [7:0] opcode_o,
  output logic pfx_seg_valid_o,
  output logic [2:0] pfx_seg_o,
  output logic pfx_opsize_o,
  output logic pfx_addrsize_o,
  output logic pfx_repne_o,
  output logic pfx_rep_o,
  output logic bus_lock_o,
  output logic has_modrm_o,
  output logic [1:0] mode_o,
  output logic [2:0] reg_o,
  output logic [2:0] rm_o,
  output logic [1:0] reg_kind_o,
  output logic has_sib_o,
  output logic [1:0] scale_o,
  output logic [2:0] index_o,
  output logic [2:0] base_o,
  output logic [2:0] disp_len_o,
  output logic [31:0] disp_o,
  output logic [2:0] imm_len_o,
  output logic [31:0] imm_o,
  output logic [1:0] op_size_o,
  output logic two_reg_o,
  output logic [3:0] extra_clk_o,
  // Fault
  output logic gp_fault_o,
  output logic [15:0] gp_err_code_o
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic ifd_pkg::ifd_attr_type opc_attr(input logic two, input logic [7:0] op);
    ifd_pkg::ifd_attr_type a;
    a = '0;
    a.imm = ifd_pkg::IMM_NONE;
    a.seg = ifd_pkg::SEG_NONE;
    if (two) begin
      a.modrm = (op[7:4] != 4'h8);
      if (op[7:4] == 4'h8) begin
        a.imm = ifd_pkg::IMM_OPSZ;
      end else if (op == 8'ha4 || op == 8'hac || op == 8'hba) begin
        a.imm = ifd_pkg::IMM_B8;
      end
    end else if (op[7:6] == 2'b00) begin
      if (op[2:1] != 2'b11) begin
        a.modrm = !op[2];
        a.has_w = 1'b1;
        a.imm = !op[2] ? ifd_pkg::IMM_NONE : (op[0] ? ifd_pkg::IMM_OPSZ : ifd_pkg::IMM_B8);
      end else if (!op[5]) begin
        a.seg = ifd_pkg::SEG_NARROW;
      end
    end else begin
      casez (op)
        8'h62, 8'h63, 8'h8d, 8'h8f, 8'hc4, 8'hc5, 8'b11011???: a.modrm = 1'b1;
        8'h69: begin
          a.modrm = 1'b1;
          a.imm = ifd_pkg::IMM_OPSZ;
        end
        8'h6b: begin
          a.modrm = 1'b1;
          a.imm = ifd_pkg::IMM_B8;
          a.sext = 1'b1;
        end
        8'h68, 8'ha9, 8'b10111???, 8'he8, 8'he9: a.imm = ifd_pkg::IMM_OPSZ;
        8'h6a: begin
          a.imm = ifd_pkg::IMM_B8;
          a.sext = 1'b1;
        end
        8'b0111????, 8'ha8, 8'b10110???, 8'hcd, 8'hd4, 8'hd5, 8'b11100???, 8'heb: a.imm = ifd_pkg::IMM_B8;
        8'b100000??: begin
          a.modrm = 1'b1;
          a.has_w = 1'b1;
          a.sext = op[`IFD_S_BIT];
          a.imm = (op[1:0] == 2'b01) ? ifd_pkg::IMM_OPSZ : ifd_pkg::IMM_B8;
        end
        8'b100001??, 8'b100010??, 8'b110100??, 8'hf6, 8'hf7, 8'hfe, 8'hff: begin
          a.modrm = 1'b1;
          a.has_w = 1'b1;
        end
        8'h8c, 8'h8e: begin
          a.modrm = 1'b1;
          a.seg = ifd_pkg::SEG_WIDE;
        end
        8'b101000??: begin
          a.moffs = 1'b1;
          a.has_w = 1'b1;
        end
        8'hc0, 8'hc1: begin
          a.modrm = 1'b1;
          a.has_w = 1'b1;
          a.imm = ifd_pkg::IMM_B8;
        end
        8'hc6, 8'hc7: begin
          a.modrm = 1'b1;
          a.has_w = 1'b1;
          a.imm = ifd_pkg::IMM_OPSZ;
        end
        8'hc2, 8'hca: a.imm = ifd_pkg::IMM_W16;
        default: a.modrm = 1'b0;
      endcase
    end
    return a;
  endfunction

  // 8-bit or fixed 16-bit immediate, else full operand size
  function automatic logic [2:0] imm_bytes(input ifd_pkg::ifd_imm_type k, input ifd_pkg::ifd_opsize_type s);
    logic [2:0] n;
    n = 3'h0;
    case (k)
      ifd_pkg::IMM_B8: n = 3'h1;
      ifd_pkg::IMM_W16: n = 3'h2;
      ifd_pkg::IMM_OPSZ: n = (s == ifd_pkg::OPS_8) ? 3'h1 : ((s == ifd_pkg::OPS_32) ? 3'h4 : 3'h2);
      default: n = 3'h0;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  ifd_pkg::ifd_state_type st_q, st_d;
  ifd_pkg::ifd_attr_type attr_q, attr_d;
  ifd_pkg::ifd_opsize_type ops_q, ops_d;
  logic [3:0] cnt_q, cnt_d, len_q, len_d, extra_q, extra_d;
  logic valid_q, valid_d, fault_q, fault_d, two_q, two_d, addr32_q, addr32_d;
  logic [7:0] opc_q, opc_d;
  logic segv_q, segv_d, opsz_q, opsz_d, adsz_q, adsz_d, repne_q, repne_d, rep_q, rep_d, lock_q, lock_d;
  logic [2:0] seg_q, seg_d;
  logic [7:0] modrm_q, modrm_d, sib_q, sib_d;
  logic sibv_q, sibv_d, tworeg_q, tworeg_d;
  logic [2:0] dlen_q, dlen_d, ilen_q, ilen_d, idx_q, idx_d;
  logic [31:0] disp_q, disp_d, imm_q, imm_d;
  logic [15:0] err_q, err_d;
  logic [3:0] cnt_n;
  logic first, opc_seen, go_data, done, op32;
  ifd_pkg::ifd_attr_type a;
  logic [2:0] il;

  ifd_cost_if cost_bus();

  assign cost_bus.two_reg = tworeg_d;
  assign cost_bus.lock = lock_d;
  assign cost_bus.op32 = (ops_d == ifd_pkg::OPS_32);
  assign cost_bus.mem_rd = mem_rd_i;
  assign cost_bus.mem_wr = mem_wr_i;
  assign cost_bus.odd_addr = odd_addr_i;
  assign cost_bus.noncached = noncached_i;
  assign cost_bus.tripled = clk_tripled_i;

  ifd_cost u_cost (
    .bus(cost_bus.calc)
  );

  always_comb begin
    st_d = st_q; attr_d = attr_q; ops_d = ops_q; cnt_d = cnt_q; len_d = len_q; extra_d = extra_q;
    two_d = two_q; addr32_d = addr32_q; opc_d = opc_q; segv_d = segv_q; seg_d = seg_q;
    opsz_d = opsz_q; adsz_d = adsz_q; repne_d = repne_q; rep_d = rep_q; lock_d = lock_q;
    modrm_d = modrm_q; sib_d = sib_q; sibv_d = sibv_q; tworeg_d = tworeg_q;
    dlen_d = dlen_q; ilen_d = ilen_q; idx_d = idx_q; disp_d = disp_q; imm_d = imm_q; err_d = err_q;
    valid_d = 1'b0;
    fault_d = 1'b0;
    cnt_n = cnt_q + 4'h1;
    first = (cnt_q == 4'h0);
    opc_seen = 1'b0;
    go_data = 1'b0;
    done = 1'b0;
    a = opc_attr(1'b0, byte_i);
    op32 = 1'b0;
    il = 3'h0;
    if (byte_valid_i) begin
      // New instruction starts clean; start address alignment is not checked
      // any start byte accepted
      if (first) begin
        two_d = 1'b0; segv_d = 1'b0; seg_d = 3'h0; opsz_d = 1'b0; adsz_d = 1'b0;
        repne_d = 1'b0; rep_d = 1'b0; lock_d = 1'b0; modrm_d = 8'h00; sib_d = 8'h00;
        sibv_d = 1'b0; tworeg_d = 1'b0; dlen_d = 3'h0; ilen_d = 3'h0; idx_d = 3'h0;
        disp_d = 32'h0; imm_d = 32'h0;
      end
      case (st_q)
        ifd_pkg::ST_PFX: begin
          case (byte_i)
            `IFD_PFX_ES: begin segv_d = 1'b1; seg_d = `IFD_SEG_ES; end
            `IFD_PFX_CS: begin segv_d = 1'b1; seg_d = `IFD_SEG_CS; end
            `IFD_PFX_SS: begin segv_d = 1'b1; seg_d = `IFD_SEG_SS; end
            `IFD_PFX_DS: begin segv_d = 1'b1; seg_d = `IFD_SEG_DS; end
            `IFD_PFX_FS: begin segv_d = 1'b1; seg_d = `IFD_SEG_FS; end
            `IFD_PFX_GS: begin segv_d = 1'b1; seg_d = `IFD_SEG_GS; end
            `IFD_PFX_OPSZ: opsz_d = 1'b1;
            `IFD_PFX_ADSZ: adsz_d = 1'b1;
            `IFD_PFX_LOCK: lock_d = 1'b1;
            `IFD_PFX_REPNE: repne_d = 1'b1;
            `IFD_PFX_REP: rep_d = 1'b1;
            `IFD_ESC_2BYTE: begin
              two_d = 1'b1;
              st_d = ifd_pkg::ST_OPC2;
            end
            default: opc_seen = 1'b1;
          endcase
        end
        ifd_pkg::ST_OPC2: begin
          a = opc_attr(1'b1, byte_i);
          opc_seen = 1'b1;
        end
        ifd_pkg::ST_MODRM: begin
          // middle field meaning set by opcode
          modrm_d = byte_i;
          il = ilen_q;
          if (!two_q && opc_q[7:1] == 7'h7b && byte_i[`IFD_MID_MSB:`IFD_MID_LSB] == 3'h0) begin
            il = imm_bytes(ifd_pkg::IMM_OPSZ, ops_q);
          end
          ilen_d = il;
          if (byte_i[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b11) begin
            go_data = 1'b1;
          end else if (addr32_q) begin
            if (byte_i[`IFD_LO_MSB:`IFD_LO_LSB] == 3'h4) begin
              sibv_d = 1'b1;
              st_d = ifd_pkg::ST_SIB;
            end else begin
              go_data = 1'b1;
              if (byte_i[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b01) begin
                dlen_d = 3'h1;
              end else if (byte_i[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b10 || byte_i[`IFD_LO_MSB:`IFD_LO_LSB] == 3'h5) begin
                dlen_d = 3'h4;
              end
            end
          end else begin
            go_data = 1'b1;
            tworeg_d = !byte_i[2];
            if (byte_i[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b01) begin
              dlen_d = 3'h1;
            end else if (byte_i[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b10 || byte_i[`IFD_LO_MSB:`IFD_LO_LSB] == 3'h6) begin
              dlen_d = 3'h2;
            end
          end
        end
        ifd_pkg::ST_SIB: begin
          sib_d = byte_i;
          go_data = 1'b1;
          il = ilen_q;
          if (byte_i[`IFD_LO_MSB:`IFD_LO_LSB] == 3'h5 && modrm_q[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b00) begin
            dlen_d = 3'h4;
          end else begin
            dlen_d = (modrm_q[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b01) ? 3'h1 :
                     ((modrm_q[`IFD_HI_MSB:`IFD_HI_LSB] == 2'b10) ? 3'h4 : 3'h0);
            tworeg_d = (byte_i[`IFD_MID_MSB:`IFD_MID_LSB] != 3'h4);
          end
        end
        ifd_pkg::ST_DISP: begin
          disp_d[{idx_q[1:0], 3'b000} +: 8] = byte_i;
          idx_d = idx_q + 3'h1;
          if (idx_d == dlen_q) begin
            idx_d = 3'h0;
            st_d = (ilen_q != 3'h0) ? ifd_pkg::ST_IMM : ifd_pkg::ST_PFX;
            done = (ilen_q == 3'h0);
          end
        end
        ifd_pkg::ST_IMM: begin
          imm_d[{idx_q[1:0], 3'b000} +: 8] = byte_i;
          idx_d = idx_q + 3'h1;
          if (idx_d == ilen_q) begin
            idx_d = 3'h0;
            st_d = ifd_pkg::ST_PFX;
            done = 1'b1;
            if (attr_q.sext && ilen_q == 3'h1) begin
              imm_d = {{24{byte_i[7]}}, byte_i};
            end
          end
        end
        default: st_d = ifd_pkg::ST_PFX;
      endcase
      if (opc_seen) begin
        opc_d = byte_i;
        attr_d = a;
        op32 = dflt_op32_i ^ (!first && opsz_q);
        addr32_d = dflt_addr32_i ^ (!first && adsz_q);
        // width bit selects byte or operand size (default toggled by the 0x66 prefix)
        if (a.has_w && !byte_i[`IFD_W_BIT]) begin
          ops_d = ifd_pkg::OPS_8;
        end else begin
          ops_d = op32 ? ifd_pkg::OPS_32 : ifd_pkg::OPS_16;
        end
        ilen_d = imm_bytes(a.imm, ops_d);
        il = ilen_d;
        if (a.modrm) begin
          st_d = ifd_pkg::ST_MODRM;
        end else begin
          go_data = 1'b1;
          dlen_d = a.moffs ? (addr32_d ? 3'h4 : 3'h2) : 3'h0;
        end
      end
      if (go_data) begin
        st_d = (dlen_d != 3'h0) ? ifd_pkg::ST_DISP : ((il != 3'h0) ? ifd_pkg::ST_IMM : ifd_pkg::ST_PFX);
        done = (dlen_d == 3'h0) && (il == 3'h0);
      end
      if (done) begin
        valid_d = 1'b1;
        len_d = cnt_n;
        cnt_d = 4'h0;
        extra_d = cost_bus.extra;
      end else if (cnt_n == MAX_LEN) begin
        fault_d = 1'b1;
        err_d = `IFD_GP_ERR_CODE;
        cnt_d = 4'h0;
        idx_d = 3'h0;
        st_d = ifd_pkg::ST_PFX;
      end else begin
        cnt_d = cnt_n;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ifd_pkg::ST_PFX; attr_q <= '0; ops_q <= ifd_pkg::OPS_8; cnt_q <= 4'h0; len_q <= 4'h0;
      extra_q <= 4'h0; valid_q <= 1'b0; fault_q <= 1'b0; two_q <= 1'b0; addr32_q <= 1'b0;
      opc_q <= 8'h00; segv_q <= 1'b0; seg_q <= 3'h0; opsz_q <= 1'b0; adsz_q <= 1'b0;
      repne_q <= 1'b0; rep_q <= 1'b0; lock_q <= 1'b0; modrm_q <= 8'h00; sib_q <= 8'h00;
      sibv_q <= 1'b0; tworeg_q <= 1'b0; dlen_q <= 3'h0; ilen_q <= 3'h0; idx_q <= 3'h0;
      disp_q <= 32'h0; imm_q <= 32'h0; err_q <= 16'h0000;
    end else begin
      st_q <= st_d; attr_q <= attr_d; ops_q <= ops_d; cnt_q <= cnt_d; len_q <= len_d;
      extra_q <= extra_d; valid_q <= valid_d; fault_q <= fault_d; two_q <= two_d; addr32_q <= addr32_d;
      opc_q <= opc_d; segv_q <= segv_d; seg_q <= seg_d; opsz_q <= opsz_d; adsz_q <= adsz_d;
      repne_q <= repne_d; rep_q <= rep_d; lock_q <= lock_d; modrm_q <= modrm_d; sib_q <= sib_d;
      sibv_q <= sibv_d; tworeg_q <= tworeg_d; dlen_q <= dlen_d; ilen_q <= ilen_d; idx_q <= idx_d;
      disp_q <= disp_d; imm_q <= imm_d; err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign insn_valid_o = valid_q;
  assign insn_len_o = len_q;
  assign two_byte_o = two_q;
  assign opcode_o = opc_q;
  assign pfx_seg_valid_o = segv_q;
  assign pfx_seg_o = seg_q;
  assign pfx_opsize_o = opsz_q;
  assign pfx_addrsize_o = adsz_q;
  assign pfx_repne_o = repne_q;
  assign pfx_rep_o = rep_q;
  assign bus_lock_o = lock_q;
  assign has_modrm_o = attr_q.modrm;
  assign mode_o = modrm_q[`IFD_HI_MSB:`IFD_HI_LSB];
  assign reg_o = modrm_q[`IFD_MID_MSB:`IFD_MID_LSB];
  assign rm_o = modrm_q[`IFD_LO_MSB:`IFD_LO_LSB];
  assign reg_kind_o = attr_q.seg;
  assign has_sib_o = sibv_q;
  assign scale_o = sib_q[`IFD_HI_MSB:`IFD_HI_LSB];
  assign index_o = sib_q[`IFD_MID_MSB:`IFD_MID_LSB];
  assign base_o = sib_q[`IFD_LO_MSB:`IFD_LO_LSB];
  assign disp_len_o = dlen_q;
  assign disp_o = disp_q;
  assign imm_len_o = ilen_q;
  assign imm_o = imm_q;
  assign op_size_o = ops_q;
  assign two_reg_o = tworeg_q;
  assign extra_clk_o = extra_q;
  assign gp_fault_o = fault_q;
  assign gp_err_code_o = err_q;

endmodule

// File: verification/ifd_instruction_decoder_props.sv
`timescale 1ns/1ps

module ifd_instruction_decoder_props #(
  parameter logic [3:0] MAX_LEN = 4'hf
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Access attributes
  input wire logic clk_tripled_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic odd_addr_i,
  input wire logic noncached_i,
  // Decoder results
  input wire logic insn_valid_o,
  input wire logic [3:0] insn_len_o,
  input wire logic two_byte_o,
  input wire logic has_modrm_o,
  input wire logic has_sib_o,
  input wire logic [1:0] mode_o,
  input wire logic [2:0] rm_o,
  input wire logic [2:0] disp_len_o,
  input wire logic [2:0] imm_len_o,
  input wire logic two_reg_o,
  input wire logic bus_lock_o,
  input wire logic [3:0] extra_clk_o,
  input wire logic gp_fault_o,
  input wire logic [15:0] gp_err_code_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Fault needs a fresh run of bytes before it can repeat
  sequence s_quiet;
    ##1 (!gp_fault_o) [*8];
  endsequence

  property p_len_range;
    insn_valid_o |-> insn_len_o != 4'h0 && insn_len_o <= MAX_LEN;
  endproperty
  a_len_range: assert property (p_len_range) else $error("length out of range");

  property p_fault_code;
    gp_fault_o |-> gp_err_code_o == 16'h0000 && !insn_valid_o;
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("bad fault code");

  property p_fault_pulse;
    gp_fault_o |-> s_quiet;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault not a pulse");

  property p_sib_ctx;
    insn_valid_o && has_sib_o |-> has_modrm_o && mode_o != 2'h3 && rm_o == 3'h4;
  endproperty
  a_sib_ctx: assert property (p_sib_ctx) else $error("index byte without form byte");

  ////////////////////////////////////////////////////////////////////////////////
  // Fields never exceed the byte count
  property p_len_sum;
    insn_valid_o |-> {1'b0, insn_len_o} >= 5'h1 + two_byte_o + has_modrm_o + has_sib_o + disp_len_o + imm_len_o;
  endproperty
  a_len_sum: assert property (p_len_sum) else $error("fields exceed length");

  property p_two_reg_clk;
    insn_valid_o && two_reg_o && $past(!mem_rd_i && !mem_wr_i) |-> extra_clk_o == 4'h1;
  endproperty
  a_two_reg_clk: assert property (p_two_reg_clk) else $error("two register cost wrong");

  property p_no_mem_clk;
    insn_valid_o && !two_reg_o && $past(!mem_rd_i && !mem_wr_i) |-> extra_clk_o == 4'h0;
  endproperty
  a_no_mem_clk: assert property (p_no_mem_clk) else $error("cost without access");

  property p_uncached;
    insn_valid_o && !two_reg_o && ($past(noncached_i) || bus_lock_o) && $past((mem_rd_i || mem_wr_i) && !odd_addr_i)
      |-> extra_clk_o == ($past(clk_tripled_i) ? 4'h4 : 4'h2);
  endproperty
  a_uncached: assert property (p_uncached) else $error("uncached cost wrong");
endmodule

bind ifd_instruction_decoder ifd_instruction_decoder_props #(.MAX_LEN(MAX_LEN)) u_props (.*);

// File: verification/ifd_prefetch_model.sv
`timescale 1ns/1ps

module ifd_prefetch_model (
  // Clock
  input wire logic clk_i,
  // Byte stream
  output logic valid_o,
  output logic [7:0] data_o
);
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
  end

  // Idle data is inverted so a stale byte never looks valid
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      @(negedge clk_i);
      valid_o = 1'b1;
      data_o = q[i];
      repeat (gap) begin
        @(negedge clk_i);
        valid_o = 1'b0;
        data_o = ~data_o;
      end
    end
    @(negedge clk_i);
    valid_o = 1'b0;
    data_o = ~data_o;
  endtask
endmodule

// File: verification/ifd_instruction_decoder_tb.sv
`timescale 1ns/1ps

module ifd_instruction_decoder_tb;
  logic core_clk_i, rstn_i, byte_valid_i, insn_valid_o, two_byte_o, pfx_seg_valid_o, pfx_opsize_o;
  logic pfx_addrsize_o, pfx_repne_o, pfx_rep_o, bus_lock_o, has_modrm_o, has_sib_o, two_reg_o, gp_fault_o;
  logic dflt_op32_i, dflt_addr32_i, clk_tripled_i, mem_rd_i, mem_wr_i, odd_addr_i, noncached_i;
  logic [1:0] mode_o, reg_kind_o, scale_o, op_size_o;
  logic [2:0] reg_o, rm_o, pfx_seg_o, index_o, base_o, disp_len_o, imm_len_o;
  logic [3:0] insn_len_o, extra_clk_o;
  logic [7:0] byte_i, opcode_o;
  logic [15:0] gp_err_code_o;
  logic [31:0] disp_o, imm_o;
  int n_fail = 0;
  int checks = 0;
  int n_ok = 0;
  int n_gp = 0;

  ifd_instruction_decoder uut (.*);
  ifd_prefetch_model pf (.clk_i(core_clk_i), .valid_o(byte_valid_i), .data_o(byte_i));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  always @(negedge core_clk_i) begin
    if (insn_valid_o === 1'b1) n_ok++;
    if (gp_fault_o === 1'b1) n_gp++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wide enough for length or size bits packed above a 32-bit field
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic set_attr(input logic [6:0] v);
    @(negedge core_clk_i);
    {dflt_op32_i, dflt_addr32_i, clk_tripled_i, mem_rd_i, mem_wr_i, odd_addr_i, noncached_i} = v;
  endtask

  // Bounded wait for n results
  task automatic run(input logic [7:0] q[$], input int gap, input int n);
    int b;
    b = n_ok + n_gp;
    pf.send(q, gap);
    for (int i = 0; i < 8 && n_ok + n_gp < b + n; i++) begin
      @(negedge core_clk_i);
      #1;
    end
    chk("events", n_ok + n_gp - b, n);
  endtask

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_walk();
    set_attr(7'b1100000);
    run('{8'h66, 8'h05, 8'h34, 8'h12}, 0, 1);
    chk("len", insn_len_o, 4'h4);
    chk("imm", {imm_len_o, imm_o}, {3'h2, 32'h1234});
    chk("opsz", {pfx_opsize_o, op_size_o}, 3'h5);
    run('{8'h66, 8'h05, 8'h34, 8'h12}, 3, 1);
    chk("len", insn_len_o, 4'h4);
    run('{8'h90, 8'h40, 8'h48}, 0, 3);
    chk("len", insn_len_o, 4'h1);
  endtask

  task automatic t_sib();
    run('{8'h8b, 8'h44, 8'h8d, 8'h80}, 0, 1);
    chk("modrm", {has_modrm_o, mode_o, reg_o, rm_o}, 9'h144);
    chk("sib", {has_sib_o, scale_o, index_o, base_o}, 9'h18d);
    chk("disp", {disp_len_o, disp_o}, {3'h1, 32'h80});
    chk("xclk", {two_reg_o, extra_clk_o}, 5'h11);
  endtask

  task automatic t_prefix();
    logic [7:0] seg[6] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65};
    logic [7:0] p[3][3] = '{'{8'hf0, 8'h3e, 8'h66}, '{8'h66, 8'hf0, 8'h3e}, '{8'h3e, 8'h66, 8'hf0}};
    set_attr(7'b1111100);
    foreach (seg[i]) begin
      run('{seg[i], 8'h90}, 0, 1);
      chk("seg", {pfx_seg_valid_o, pfx_seg_o}, {1'b1, i[2:0]});
    end
    foreach (p[k]) begin
      run('{p[k][0], p[k][1], p[k][2], 8'h01, 8'h00}, 0, 1);
      chk("pfx", {bus_lock_o, pfx_seg_o, op_size_o}, 6'h2d);
      chk("xclk", extra_clk_o, 4'h4);
    end
    run('{8'hf2, 8'hf3, 8'h67, 8'h90}, 0, 1);
    chk("rep", {pfx_repne_o, pfx_rep_o, pfx_addrsize_o}, 3'h7);
  endtask

  task automatic t_size();
    logic [6:0] a[4] = '{7'b1100110, 7'b1101110, 7'b1101111, 7'b1111001};
    logic [3:0] e[4] = '{4'h1, 4'h2, 4'h4, 4'h4};
    foreach (a[i]) begin
      set_attr(a[i]);
      run('{8'h89, 8'h00}, 0, 1);
      chk("xclk", extra_clk_o, e[i]);
    end
  endtask

  task automatic t_fields();
    set_attr(7'b1100000);
    run('{8'h83, 8'hc0, 8'hff}, 0, 1);
    chk("imm", {op_size_o, imm_o}, {2'h2, 32'hffffffff});
    run('{8'h80, 8'hc0, 8'hff}, 0, 1);
    chk("imm", {op_size_o, imm_o}, {2'h0, 32'hff});
    run('{8'h8b, 8'h05, 8'h44, 8'h33, 8'h22, 8'h11}, 0, 1);
    chk("disp", {disp_len_o, disp_o}, {3'h4, 32'h11223344});
    run('{8'h67, 8'h8b, 8'h06, 8'h34, 8'h12}, 0, 1);
    chk("disp", {disp_len_o, disp_o}, {3'h2, 32'h1234});
    // 16-bit base plus index form
    run('{8'h67, 8'h8b, 8'h00}, 0, 1);
    chk("xclk", {two_reg_o, extra_clk_o}, 5'h11);
    run('{8'h0f, 8'hb6, 8'hc0}, 0, 1);
    chk("esc", {two_byte_o, opcode_o}, 9'h1b6);
    t_sib();
    run('{8'h8e, 8'hd8}, 0, 1);
    chk("rkind", {reg_kind_o, reg_o}, 5'h0b);
    run('{8'h1e}, 0, 1);
    chk("rkind", reg_kind_o, 2'h2);
  endtask

  task automatic t_len();
    logic [7:0] q[$];
    int g;
    repeat (10) q.push_back(8'h3e);
    q = {q, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12};
    run(q, 0, 1);
    chk("len", insn_len_o, 4'hf);
    q = {};
    repeat (15) q.push_back(8'hf0);
    g = n_gp;
    run(q, 0, 1);
    chk("gp", {n_gp - g, gp_err_code_o}, {32'h1, 16'h0});
    run('{8'h90}, 0, 1);
    chk("len", insn_len_o, 4'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    {dflt_op32_i, dflt_addr32_i, clk_tripled_i, mem_rd_i, mem_wr_i, odd_addr_i, noncached_i} = 7'h00;
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk("rst", {insn_valid_o, gp_fault_o, insn_len_o, op_size_o}, 8'h00);
    t_walk();
    t_fields();
    t_prefix();
    t_size();
    t_len();
    conclude();
  end

  // About twenty times the expected run
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule
